// ===== design/rlr_pkg.sv
// Package for the remote limit, lock and result register slice
package rlr_pkg;
	// Command bytes selecting each register
	localparam logic [7:0] CMD_RESULT_MSB = 8'h01;
	localparam logic [7:0] CMD_CONFIG = 8'h03;
	localparam logic [7:0] CMD_HIGH_MSB = 8'h07;
	localparam logic [7:0] CMD_LOW_MSB = 8'h08;
	localparam logic [7:0] CMD_LOCK = 8'h09;
	localparam logic [7:0] CMD_RESULT_LSB = 8'h10;
	localparam logic [7:0] CMD_HIGH_LSB = 8'h13;
	localparam logic [7:0] CMD_LOW_LSB = 8'h14;
	// Values after reset
	localparam logic [7:0] HIGH_MSB_RST = 8'h50;
	localparam logic [7:0] LOW_MSB_RST = 8'h00;
	localparam logic [3:0] LIMIT_LSB_RST = 4'h0;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [4:0] LOCK_RST = 5'h00;
	localparam logic INT_EN_RST = 1'b1;
	// Field positions
	localparam int CFG_IE_BIT = 7;
	localparam int CFG_SHUTDOWN_SELECT_BIT = 6;
	localparam int CFG_RST_BIT = 0;
	localparam int LOCK_WIDTH = 5;
	// Bits in one serial byte, counted by scl rising edges
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef struct packed {
		logic warm_reset_lockout;
		logic shutdown_lockout;
		logic diode_fault_lock;
		logic remote_overtemp_lock;
		logic local_overtemp_lock;
	} rlr_lock_t;

	typedef struct packed {
		logic [7:0] whole;
		logic [3:0] frac;
	} rlr_result_t;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ACK_ADDR = 9'h004,
		ST_CMD = 9'h008,
		ST_ACK_CMD = 9'h010,
		ST_WDATA = 9'h020,
		ST_ACK_W = 9'h040,
		ST_RDATA = 9'h080,
		ST_ACK_R = 9'h100
	} rlr_state_t;
endpackage

// ===== design/rlr_regs.sv
// Two-wire register slave with remote limits, security lock and coherent result word
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Remote high limit high byte is read/write, 0x50 after reset.
// - Remote low limit high byte is read/write, zero after reset.
// - Limit high bytes are whole degrees in two's complement.
// - Writing a limit register purges that limit's fault queue.
// - Security register is 5 bits; lock bits take only one write.
// - Warm reset lockout set makes the software reset bit ignored.
// - Shutdown lockout set refuses requests to enter shutdown.
// - Diode fault lock bit locks the diode fault event.
// - Remote over-temperature lock bit locks that event.
// - Local over-temperature lock bit locks that event; clear after reset.
// - Result low byte is read-only, fraction in upper nibble, low nibble zero.
// - Fraction step is one sixteenth degree, bit four as its weight.
// - Word read of command 0x01 returns result high then low byte.
// - Both bytes of that word come from one conversion.
// - Only the result high byte supports word reads.
// - Result low byte reads zero until the first conversion completes.
// - Software reset bit restores all defaults unless warm reset locked.
// - Shutdown select: zero normal operation, one low-power shutdown.
module rlr_regs #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a // Arbitrary value
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic conv_done_i,
	input wire rlr_pkg::rlr_result_t result_i,
	output logic fq_purge_high_o,
	output logic fq_purge_low_o,
	output logic fq_purge_all_o,
	output logic remote_high_hit_o,
	output logic remote_low_hit_o,
	output rlr_pkg::rlr_lock_t lock_o,
	output logic shutdown_o,
	output logic int_enable_o,
	output logic sw_reset_o
);
	import rlr_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	rlr_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic rw_reg;
	logic word_phase_reg;
	logic master_ack_reg;
	logic [7:0] snap_lsb_reg;
	logic wr_en;
	logic [7:0] high_msb_reg;
	logic [7:0] low_msb_reg;
	logic [3:0] high_lsb_reg;
	logic [3:0] low_lsb_reg;
	logic [7:0] result_msb_reg;
	logic [7:0] result_lsb_reg;
	logic lock_written_reg;
	logic soft_rst_reg;
	logic srst;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic byte_done;
	logic [11:0] result_word;
	logic [11:0] high_thresh;
	logic [11:0] low_thresh;
	logic [7:0] rd_byte;

	function automatic logic [7:0] read_byte(input logic [7:0] cmd);
		case (cmd)
			CMD_RESULT_MSB: read_byte = result_msb_reg;
			CMD_CONFIG: read_byte = {int_enable_o, shutdown_o, 6'h00};
			CMD_HIGH_MSB: read_byte = high_msb_reg;
			CMD_LOW_MSB: read_byte = low_msb_reg;
			CMD_LOCK: read_byte = {3'h0, lock_o};
			CMD_RESULT_LSB: read_byte = result_lsb_reg;
			CMD_HIGH_LSB: read_byte = {high_lsb_reg, 4'h0};
			CMD_LOW_LSB: read_byte = {low_lsb_reg, 4'h0};
			default: read_byte = 8'h00;
		endcase
	endfunction
	always_comb rd_byte = read_byte(ptr_reg);

	////////////////////////////////////////////////////////////////////
	// Pins cross in through two flops; edges are seen on the second only
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl_rise = scl_sync_reg[1] && !scl_prev_reg;
	assign scl_fall = !scl_sync_reg[1] && scl_prev_reg;
	assign start_seen = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
	assign stop_seen = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];
	assign byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
	assign wr_en = byte_done && (state_reg == ST_WDATA);
	assign srst = rst_i || soft_rst_reg;

	////////////////////////////////////////////////////////////////////
	// Serial protocol engine; data moves only while scl is low
	always_ff @(posedge core_clk_i) begin
		sda_o <= 1'b0;
		if (rst_i) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			word_phase_reg <= 1'b0;
			master_ack_reg <= 1'b0;
			snap_lsb_reg <= RESULT_RST;
			sda_oe_o <= 1'b0;
		end else if (start_seen) begin
			state_reg <= ST_ADDR;
			bit_cnt_reg <= 4'h0;
			word_phase_reg <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (stop_seen) begin
			state_reg <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end else if (scl_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
			master_ack_reg <= !sda_sync_reg[1];
		end else if (scl_fall) begin
			case (state_reg)
				ST_ADDR: begin
					if (byte_done && shift_reg[7:1] == SLAVE_ADDR) begin
						rw_reg <= shift_reg[0];
						sda_oe_o <= 1'b1;
						state_reg <= ST_ACK_ADDR;
					end else if (byte_done) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_ACK_ADDR: begin
					bit_cnt_reg <= 4'h0;
					if (rw_reg) begin
						// Low byte caught with the high byte: one conversion
						snap_lsb_reg <= result_lsb_reg;
						sda_oe_o <= !rd_byte[7];
						tx_reg <= {rd_byte[6:0], 1'b0};
						state_reg <= ST_RDATA;
					end else begin
						sda_oe_o <= 1'b0;
						state_reg <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (byte_done) begin
						ptr_reg <= shift_reg;
						sda_oe_o <= 1'b1;
						state_reg <= ST_ACK_CMD;
					end
				end
				ST_ACK_CMD: begin
					bit_cnt_reg <= 4'h0;
					sda_oe_o <= 1'b0;
					state_reg <= ST_WDATA;
				end
				ST_WDATA: begin
					if (byte_done) begin
						sda_oe_o <= 1'b1;
						state_reg <= ST_ACK_W;
					end
				end
				ST_ACK_W: begin
					// Single byte writes only; later bytes go unacknowledged
					sda_oe_o <= 1'b0;
					state_reg <= ST_IDLE;
				end
				ST_RDATA: begin
					if (byte_done) begin
						sda_oe_o <= 1'b0;
						state_reg <= ST_ACK_R;
					end else begin
						sda_oe_o <= !tx_reg[7];
						tx_reg <= {tx_reg[6:0], 1'b0};
					end
				end
				ST_ACK_R: begin
					bit_cnt_reg <= 4'h0;
					if (master_ack_reg && !word_phase_reg && ptr_reg == CMD_RESULT_MSB) begin
						word_phase_reg <= 1'b1;
						sda_oe_o <= !snap_lsb_reg[7];
						tx_reg <= {snap_lsb_reg[6:0], 1'b0};
						state_reg <= ST_RDATA;
					end else begin
						sda_oe_o <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					sda_oe_o <= 1'b0;
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Limit registers and fault queue purge strobes
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			high_msb_reg <= HIGH_MSB_RST;
			low_msb_reg <= LOW_MSB_RST;
			high_lsb_reg <= LIMIT_LSB_RST;
			low_lsb_reg <= LIMIT_LSB_RST;
			fq_purge_high_o <= 1'b0;
			fq_purge_low_o <= 1'b0;
		end else begin
			if (wr_en && ptr_reg == CMD_HIGH_MSB)
				high_msb_reg <= shift_reg;
			if (wr_en && ptr_reg == CMD_LOW_MSB)
				low_msb_reg <= shift_reg;
			if (wr_en && ptr_reg == CMD_HIGH_LSB)
				high_lsb_reg <= shift_reg[7:4];
			if (wr_en && ptr_reg == CMD_LOW_LSB)
				low_lsb_reg <= shift_reg[7:4];
			fq_purge_high_o <= wr_en && (ptr_reg == CMD_HIGH_MSB || ptr_reg == CMD_HIGH_LSB);
			fq_purge_low_o <= wr_en && (ptr_reg == CMD_LOW_MSB || ptr_reg == CMD_LOW_LSB);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration and security lock
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			lock_o <= LOCK_RST;
			lock_written_reg <= 1'b0;
			shutdown_o <= 1'b0;
			int_enable_o <= INT_EN_RST;
			soft_rst_reg <= 1'b0;
			fq_purge_all_o <= 1'b0;
		end else begin
			// Upper three bits are dropped; they read back as zero
			if (wr_en && ptr_reg == CMD_LOCK && !lock_written_reg) begin
				lock_o <= shift_reg[LOCK_WIDTH-1:0];
				lock_written_reg <= 1'b1;
			end
			if (wr_en && ptr_reg == CMD_CONFIG) begin
				int_enable_o <= shift_reg[CFG_IE_BIT];
				// A locked device may leave shutdown but never enter it
				if (!(lock_o.shutdown_lockout && shift_reg[CFG_SHUTDOWN_SELECT_BIT]))
					shutdown_o <= shift_reg[CFG_SHUTDOWN_SELECT_BIT];
			end
			soft_rst_reg <= wr_en && ptr_reg == CMD_CONFIG && shift_reg[CFG_RST_BIT]
				&& !lock_o.warm_reset_lockout;
			fq_purge_all_o <= wr_en && ptr_reg == CMD_CONFIG;
		end
	end

	assign sw_reset_o = soft_rst_reg;

	////////////////////////////////////////////////////////////////////
	// Result capture and threshold compare
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			result_msb_reg <= RESULT_RST;
			result_lsb_reg <= RESULT_RST;
		end else if (conv_done_i) begin
			result_msb_reg <= result_i.whole;
			result_lsb_reg <= {result_i.frac, 4'h0};
		end
	end

	assign result_word = {result_msb_reg, result_lsb_reg[7:4]};
	assign high_thresh = {high_msb_reg, high_lsb_reg};
	assign low_thresh = {low_msb_reg, low_lsb_reg};

	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			remote_high_hit_o <= 1'b0;
			remote_low_hit_o <= 1'b0;
		end else begin
			// Signed compare: whole degrees are two's complement
			remote_high_hit_o <= $signed(result_word) > $signed(high_thresh);
			remote_low_hit_o <= $signed(result_word) < $signed(low_thresh);
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence s_word_first;
		scl_fall && state_reg == ST_ACK_ADDR && rw_reg && ptr_reg == CMD_RESULT_MSB;
	endsequence

	a_high_reset: assert property (@(posedge core_clk_i) rst_i |=>
		high_msb_reg == HIGH_MSB_RST) else $error("high limit reset value wrong");
	a_low_reset: assert property (@(posedge core_clk_i) rst_i |=>
		low_msb_reg == LOW_MSB_RST) else $error("low limit reset value wrong");
	a_purge_high: assert property (@(posedge core_clk_i) disable iff (srst)
		wr_en && ptr_reg == CMD_HIGH_MSB |=> fq_purge_high_o && high_msb_reg == $past(shift_reg))
		else $error("high limit write without purge");
	a_lock_once: assert property (@(posedge core_clk_i) disable iff (srst)
		lock_written_reg |=> $stable(lock_o)) else $error("lock changed after first write");
	a_rst_lockout: assert property (@(posedge core_clk_i) disable iff (rst_i)
		lock_o.warm_reset_lockout && !soft_rst_reg |=> !soft_rst_reg) else $error("reset not locked");
	a_shutdown_select_lockout: assert property (@(posedge core_clk_i) disable iff (srst)
		lock_o.shutdown_lockout && !shutdown_o |=> !shutdown_o) else $error("shutdown while locked");
	a_frac_place: assert property (@(posedge core_clk_i) disable iff (srst)
		conv_done_i |=> result_lsb_reg == {$past(result_i.frac), 4'h0}) else $error("bad fraction");
	a_lsb_nibble: assert property (@(posedge core_clk_i) disable iff (srst)
		scl_fall && state_reg == ST_ACK_ADDR && rw_reg && ptr_reg == CMD_RESULT_LSB
		|=> tx_reg[4:1] == 4'h0) else $error("result low nibble not zero");
	a_word_snap: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_word_first |=> snap_lsb_reg == $past(result_lsb_reg) && state_reg == ST_RDATA)
		else $error("word read snapshot wrong");
	a_high_cmp: assert property (@(posedge core_clk_i) disable iff (srst)
		$signed(result_word) > $signed(high_thresh) |=> remote_high_hit_o) else $error("high miss");
endmodule

`default_nettype wire

// ===== tb/rlr_host.sv
// Two-wire host model that drives the register slave
`timescale 1ns/1ns
`default_nettype none
module rlr_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	// SDA moves only while SCL is low, well after the slave has seen the fall
	task automatic bit_io(input logic b, output logic q);
		sda_low_o = !b;
		wt(5);
		scl_o = 1'b1;
		wt(10);
		q = sda_i;
		scl_o = 1'b0;
		wt(5);
	endtask
	// Also serves as repeated start, entered with SCL low
	task automatic start();
		sda_low_o = 1'b0;
		wt(5);
		scl_o = 1'b1;
		wt(10);
		sda_low_o = 1'b1;
		wt(10);
		scl_o = 1'b0;
		wt(5);
	endtask
	task automatic stop();
		sda_low_o = 1'b1;
		wt(5);
		scl_o = 1'b1;
		wt(10);
		sda_low_o = 1'b0;
		wt(10);
	endtask
	// Eight bits MSB first, then the acknowledge slot; all ones releases the line
	task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
		output logic s_ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(!m_ack, a);
		s_ack = !a;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the remote limit, lock and result register slice
`timescale 1ns/1ns
`default_nettype none
module tb;
	import rlr_pkg::*;
	localparam logic [6:0] ADDR = 7'h2a;
	logic core_clk_i, rst_i, conv_done_i, scl, sda_low, sda_o, sda_oe_o, sda;
	logic fq_purge_high_o, fq_purge_low_o, fq_purge_all_o, remote_high_hit_o, remote_low_hit_o;
	logic shutdown_o, int_enable_o, sw_reset_o;
	rlr_result_t result_i;
	rlr_lock_t lock_o;
	int failures, n_compared, n_ph, n_pl, n_sw, n_pa;
	logic [15:0] v;
	// Open-drain wire with pull-up
	assign sda = (sda_oe_o ? sda_o : 1'b1) & !sda_low;
	rlr_regs #(.SLAVE_ADDR(ADDR)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_done_i(conv_done_i),
		.result_i(result_i), .fq_purge_high_o(fq_purge_high_o), .fq_purge_low_o(fq_purge_low_o),
		.fq_purge_all_o(fq_purge_all_o), .remote_high_hit_o(remote_high_hit_o),
		.remote_low_hit_o(remote_low_hit_o), .lock_o(lock_o), .shutdown_o(shutdown_o),
		.int_enable_o(int_enable_o), .sw_reset_o(sw_reset_o));
	rlr_host host (.clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		n_ph <= n_ph + int'(fq_purge_high_o === 1'b1);
		n_pl <= n_pl + int'(fq_purge_low_o === 1'b1);
		n_sw <= n_sw + int'(sw_reset_o === 1'b1);
		n_pa <= n_pa + int'(fq_purge_all_o === 1'b1);
	end
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic do_reset();
		rst_i = 1'b1;
		repeat (5) @(negedge core_clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		logic [7:0] q;
		logic a, b, c;
		host.start();
		host.byte_io({ADDR, 1'b0}, 1'b0, q, a);
		host.byte_io(cmd, 1'b0, q, b);
		host.byte_io(d, 1'b0, q, c);
		host.stop();
		chk("write acks", {5'h0, a, b, c}, 8'h07);
	endtask
	task automatic rd(input logic [7:0] cmd, input logic word, output logic [15:0] r);
		logic a;
		r = 16'hffff;
		host.start();
		host.byte_io({ADDR, 1'b0}, 1'b0, r[15:8], a);
		host.byte_io(cmd, 1'b0, r[15:8], a);
		host.start();
		host.byte_io({ADDR, 1'b1}, 1'b0, r[15:8], a);
		host.byte_io(8'hff, word, r[15:8], a);
		if (word) host.byte_io(8'hff, 1'b0, r[7:0], a);
		host.stop();
	endtask
	task automatic rc(input logic [7:0] cmd, input logic [7:0] exp);
		logic [15:0] r;
		rd(cmd, 1'b0, r);
		chk($sformatf("reg %h", cmd), r[15:8], exp);
	endtask
	task automatic cv(input logic [7:0] w, input logic [3:0] f);
		result_i = {w, f};
		conv_done_i = 1'b1;
		@(negedge core_clk_i);
		conv_done_i = 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		rc(CMD_HIGH_MSB, 8'h50);
		rc(CMD_LOW_MSB, 8'h00);
		rc(CMD_LOCK, 8'h00);
		rc(CMD_RESULT_LSB, 8'h00);
		rc(CMD_CONFIG, 8'h80);
	endtask
	task automatic t_limits();
		int p, q;
		p = n_ph;
		q = n_pl;
		wr(CMD_HIGH_MSB, 8'h19);
		chk("purge high", 8'(n_ph - p), 8'h01);
		wr(CMD_LOW_MSB, 8'hf6);
		chk("purge low", 8'(n_pl - q), 8'h01);
		rc(CMD_LOW_MSB, 8'hf6);
		cv(8'h19, 4'h1);
		chk("high hit", {7'h0, remote_high_hit_o}, 8'h01);
		cv(8'h19, 4'h0);
		chk("high edge", {7'h0, remote_high_hit_o}, 8'h00);
		// Minus 10.0625 sits just under the minus 10 threshold
		cv(8'hf5, 4'hf);
		chk("low hit", {7'h0, remote_low_hit_o}, 8'h01);
		cv(8'h19, 4'h1);
		rc(CMD_RESULT_LSB, 8'h10);
		wr(CMD_RESULT_LSB, 8'hff);
		rc(CMD_RESULT_LSB, 8'h10);
		// Limit low bytes purge too and take part in the threshold
		p = n_ph;
		q = n_pl;
		wr(CMD_HIGH_LSB, 8'h2f);
		wr(CMD_LOW_LSB, 8'h30);
		chk("purge high lsb", 8'(n_ph - p), 8'h01);
		chk("purge low lsb", 8'(n_pl - q), 8'h01);
		rc(CMD_HIGH_LSB, 8'h20);
		cv(8'h19, 4'h2);
		chk("high nibble", {7'h0, remote_high_hit_o}, 8'h00);
		cv(8'h19, 4'h1);
	endtask
	// A conversion lands while the high byte is shifting out
	task automatic t_word();
		fork
			rd(CMD_RESULT_MSB, 1'b1, v);
			begin
				repeat (700) @(negedge core_clk_i);
				cv(8'h20, 4'h8);
			end
		join
		chk("word msb", v[15:8], 8'h19);
		chk("word lsb", v[7:0], 8'h10);
		rc(CMD_RESULT_LSB, 8'h80);
		rd(CMD_HIGH_MSB, 1'b1, v);
		chk("no word", v[7:0], 8'hff);
	endtask
	task automatic t_config();
		int s, a;
		s = n_sw;
		a = n_pa;
		// Interrupt enable is cleared by this write, then the reset restores it
		wr(CMD_CONFIG, 8'h01);
		chk("sw reset", 8'(n_sw - s), 8'h01);
		chk("purge all", 8'(n_pa - a), 8'h01);
		rc(CMD_HIGH_MSB, 8'h50);
		rc(CMD_CONFIG, 8'h80);
		wr(CMD_CONFIG, 8'hc0);
		chk("shutdown on", {7'h0, shutdown_o}, 8'h01);
		wr(CMD_CONFIG, 8'h80);
		chk("shutdown off", {7'h0, shutdown_o}, 8'h00);
	endtask
	task automatic t_lock();
		int s;
		wr(CMD_LOCK, 8'h0c);
		chk("lock", {3'h0, lock_o}, 8'h0c);
		wr(CMD_LOCK, 8'h13);
		rc(CMD_LOCK, 8'h0c);
		wr(CMD_CONFIG, 8'hc0);
		chk("locked shutdown", {7'h0, shutdown_o}, 8'h00);
		do_reset();
		wr(CMD_HIGH_MSB, 8'h33);
		wr(CMD_LOCK, 8'h13);
		chk("lock two", {3'h0, lock_o}, 8'h13);
		s = n_sw;
		wr(CMD_CONFIG, 8'h81);
		chk("no sw reset", 8'(n_sw - s), 8'h00);
		rc(CMD_HIGH_MSB, 8'h33);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{failures, n_compared, n_ph, n_pl, n_sw, n_pa} = '0;
		conv_done_i = 1'b0;
		result_i = '0;
		do_reset();
		t_defaults();
		t_limits();
		t_word();
		t_config();
		t_lock();
		report_and_stop();
	end
	initial begin
		repeat (90000) @(posedge core_clk_i);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
